/* File: bench/mii_link_partner.sv */
// MII MAC partner facing port 4 in PHY mode
`timescale 1ns/1ps
`default_nettype none
module mii_link_partner (
    input  wire logic       tx_clock,
    input  wire logic       rx_clock,
    input  wire logic       rx_valid,
    input  wire logic [3:0] rx_data,
    output logic            tx_enable,
    output logic      [3:0] tx_data
);
    logic [7:0] rx_q[$];
    logic [3:0] lo;
    logic       half;
    initial begin
        tx_enable = 1'b0;
        tx_data   = 4'h0;
        half      = 1'b0;
    end
    // Drive on the falling edge, away from the device's sampling edge
    task automatic send_frame(input logic [7:0] q[$]);
        foreach (q[i]) begin
            for (int n = 0; n < 2; n++) begin
                @(negedge tx_clock);
                tx_enable <= 1'b1;
                tx_data   <= n ? q[i][7:4] : q[i][3:0];
            end
        end
        @(negedge tx_clock);
        tx_enable <= 1'b0;
        tx_data   <= ~tx_data;
    endtask : send_frame
    always @(negedge rx_clock) begin
        half <= rx_valid && !half;
        lo   <= rx_data;
        if (rx_valid && half)
            rx_q.push_back({rx_data, lo});
    end
endmodule : mii_link_partner
`default_nettype wire

/* File: bench/mii_port_straps_sva.sv */
// Assertion checker for the MII/RMII port strap block
`timescale 1ns/1ps
`default_nettype none
module mii_port_straps_sva (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       p3_mii_mode,
    input wire logic       p4_mii_mode,
    input wire logic       p4_phy_mode,
    input wire logic       clock_mode_select_strap,
    input wire logic       rmii_ref_out_enable,
    input wire logic [3:0] p3_rx_pins_in,
    input wire logic [3:0] p4_rx_pins_in,
    input wire logic [3:0] p3_rx_pins_oe_n,
    input wire logic [3:0] p4_rx_pins_oe_n,
    input wire logic       p3_rx_valid,
    input wire logic       p3_sw_rx_valid,
    input wire logic       p3_carrier_sense,
    input wire logic       p3_collision,
    input wire logic       p3_sw_carrier,
    input wire logic       p3_sw_collision,
    input wire logic       p3_backpressure_en,
    input wire logic       p3_keep_collided,
    input wire logic       p3_aggressive_backoff,
    input wire logic       p3_flowctl_en,
    input wire logic       p4_fd_flowctl_en,
    input wire logic       p4_half_duplex,
    input wire logic       p4_speed_10,
    input wire logic       p4_tx_clock_oe_n,
    input wire logic       p4_rx_clock_oe_n,
    input wire logic       p4_rx_clock_out,
    input wire logic       p4_crs_valid,
    input wire logic       ing_overflow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire [3:0] p3_cfg = {!p3_flowctl_en, p3_backpressure_en, p3_keep_collided,
                         p3_aggressive_backoff};
    wire [2:0] p4_cfg = {p4_fd_flowctl_en, p4_half_duplex, p4_speed_10};
    wire [3:0] modes  = {p4_mii_mode, p4_phy_mode, clock_mode_select_strap, rmii_ref_out_enable};
    wire       phy    = p4_mii_mode && p4_phy_mode;

    strap_p3_a: assert property ($fell(rst) |->
        ##3 p3_cfg == $past(p3_rx_pins_in, 3))
        else $error("port 3 strap value wrong");
    strap_p4_a: assert property ($fell(rst) |->
        ##3 p4_cfg == $past(p4_rx_pins_in[3:1], 3))
        else $error("port 4 strap value wrong");
    strap_hold_a: assert property (!rst ##1 !rst ##1 !rst |=> $stable({p3_cfg, p4_cfg}))
        else $error("strap value changed");
    pin_release_a: assert property ($fell(rst) |->
        &{p3_rx_pins_oe_n, p4_rx_pins_oe_n} ##1 !{p3_rx_pins_oe_n, p4_rx_pins_oe_n})
        else $error("rx pin drive timing wrong");
    tx_clk_dir_a: assert property (!$past(rst) && $stable(modes) |->
        p4_tx_clock_oe_n == !phy)
        else $error("tx clock direction wrong");
    rx_clk_dir_a: assert property (!$past(rst) && $stable(modes) |->
        p4_rx_clock_oe_n == !(phy ||
        !p4_mii_mode && clock_mode_select_strap && rmii_ref_out_enable))
        else $error("rx clock direction wrong");
    ref_toggle_a: assert property ((!p4_mii_mode && !p4_rx_clock_oe_n) [*2] |->
        p4_rx_clock_out != $past(p4_rx_clock_out))
        else $error("reference clock not at half rate");
    p3_status_a: assert property (!$past(rst) && $stable(p3_mii_mode) |->
        {p3_carrier_sense, p3_collision} ==
        ({$past(p3_sw_carrier), $past(p3_sw_collision)} & {2{p3_mii_mode}}))
        else $error("port 3 carrier or collision wrong");
    p3_valid_a: assert property (!$past(rst) |-> p3_rx_valid == $past(p3_sw_rx_valid))
        else $error("port 3 valid wrong");

    cover property ($fell(rst));
    cover property ($rose(p4_crs_valid));
    cover property (ing_overflow);
    cover property (!p4_mii_mode && !p4_rx_clock_oe_n);
endmodule : mii_port_straps_sva

bind mii_port_straps mii_port_straps_sva u_sva (.*);
`default_nettype wire

/* File: bench/switch_mii_rmii_port_straps_tb_top.sv */
// Self-checking bench for the MII/RMII port strap block
`timescale 1ns/1ps
`default_nettype none
`include "mii_port_regs.svh"
module switch_mii_rmii_port_straps_tb_top;
    logic       clk, rst, p3_mii_mode, p4_mii_mode, p4_phy_mode, clock_mode_select_strap;
    logic       rmii_ref_out_enable, p3_sw_rx_valid, p3_sw_carrier, p3_sw_collision;
    logic       p4_tx_enable, p4_tx_clock_in, p4_rx_clock_in, ing_ready, eg_last, eg_valid;
    logic       p3_rx_valid, p3_carrier_sense, p3_collision, p3_backpressure_en, p3_keep_collided;
    logic       p3_aggressive_backoff, p3_flowctl_en, p4_fd_flowctl_en, p4_half_duplex;
    logic       p4_speed_10, p4_tx_clock_out, p4_tx_clock_oe_n, p4_rx_clock_out;
    logic       p4_rx_clock_oe_n, p4_crs_valid, ing_last, ing_valid, ing_overflow, eg_ready, hold;
    logic [3:0] p3_rx_pins_in, p3_sw_rx_data, p4_tx_data, p4_rx_pins_in, p3_rx_pins_out;
    logic [3:0] p3_rx_pins_oe_n, p4_rx_pins_out, p4_rx_pins_oe_n, s3, s4, d;
    logic [7:0] ing_data, eg_data, exp[$];
    logic [8:0] got[$];
    int         num_errors, num_checks, ovf, seed = 32'h697e28bb;

    mii_port_straps dut (.*);
    mii_link_partner u_partner (.tx_clock(p4_tx_clock_out), .rx_clock(p4_rx_clock_out),
        .rx_valid(p4_crs_valid), .rx_data(p4_rx_pins_out), .tx_enable(p4_tx_enable),
        .tx_data(p4_tx_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) ing_ready <= hold ? 1'b0 : $random(seed);
    always @(posedge clk) begin
        if (ing_overflow === 1'b1)
            ovf <= ovf + 1;
        if (ing_valid === 1'b1 && ing_ready === 1'b1)
            got.push_back({ing_last, ing_data});
    end

    task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
        num_checks++;
        if (got_v !== exp_v) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask : check
    task automatic stop_test;
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic send_byte(input logic [7:0] b, input logic l);
        int t;
        eg_data  <= b;
        eg_last  <= l;
        eg_valid <= 1'b1;
        for (t = 0; t < 5000; t++) begin
            @(posedge clk);
            if (eg_ready === 1'b1)
                break;
        end
        if (t == 5000) begin
            num_errors++;
            stop_test();
        end
    endtask : send_byte

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    initial begin
        {rst, hold, p3_mii_mode, p4_mii_mode, p4_phy_mode, clock_mode_select_strap} <= 6'h30;
        {rmii_ref_out_enable, p3_sw_rx_valid, p3_sw_carrier, p3_sw_collision} <= 4'h0;
        {p4_tx_clock_in, p4_rx_clock_in, eg_last, eg_valid, ing_ready} <= 5'h0;
        {p3_rx_pins_in, p3_sw_rx_data, p4_rx_pins_in, eg_data} <= 20'h0;
        for (int r = 0; r < 3; r++) begin
            @(posedge clk);
            s3 = r ? $random(seed) : 4'h0;
            s4 = r ? $random(seed) : 4'h0;
            rst           <= 1'b1;
            p3_rx_pins_in <= s3;
            p4_rx_pins_in <= s4;
            repeat (r ? 3 : 20) @(posedge clk);
            rst <= 1'b0;
            repeat (4) @(posedge clk);
            p3_rx_pins_in <= ~s3;
            p4_rx_pins_in <= ~s4;
            repeat (2) @(posedge clk);
            #1;
            check({p3_flowctl_en, p3_backpressure_en, p3_keep_collided, p3_aggressive_backoff},
                {~s3[3], s3[2:0]});
            check({p4_fd_flowctl_en, p4_half_duplex, p4_speed_10}, s4[3:1]);
        end
        for (int m = 0; m < 16; m++) begin
            @(posedge clk);
            {p4_mii_mode, p4_phy_mode, clock_mode_select_strap, rmii_ref_out_enable} <= m[3:0];
            repeat (3) @(posedge clk);
            #1;
            check(p4_tx_clock_oe_n, !(m[3] && m[2]));
            check(p4_rx_clock_oe_n, !(m[3] && m[2] || !m[3] && m[1] && m[0]));
        end
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            d = $random(seed);
            {p3_mii_mode, p3_sw_rx_valid, p3_sw_carrier, p3_sw_collision} <= $random(seed);
            p3_sw_rx_data <= d;
            @(posedge clk);
            #1;
            check(p3_rx_valid, p3_sw_rx_valid);
            check({p3_carrier_sense, p3_collision},
                {p3_sw_carrier, p3_sw_collision} & {2{p3_mii_mode}});
            check(p3_rx_pins_out, p3_mii_mode ? d : {2'h0, d[1:0]});
        end
        @(posedge clk);
        exp.delete();
        for (int i = 0; i < 6; i++) exp.push_back($random(seed));
        foreach (exp[i]) send_byte(exp[i], i == 5);
        eg_valid <= 1'b0;
        for (int t = 0; t < 4000 && u_partner.rx_q.size() < 6; t++) @(posedge clk);
        check(u_partner.rx_q.size(), 6);
        foreach (exp[i]) check(u_partner.rx_q[i], exp[i]);
        for (int f = 0; f < 2; f++) begin
            hold <= !f;
            ovf = 0;
            got.delete();
            exp.delete();
            for (int i = 0; i < (f ? 5 : 12); i++) exp.push_back($random(seed));
            u_partner.send_frame(exp);
            repeat (20) @(posedge clk);
            hold <= 1'b0;
            repeat (400) @(posedge clk);
            check(ovf != 0, !f);
            check(f ? got.size() == 5 : got.size() >= `MP_FIFO_DEPTH, 1'b1);
            foreach (got[i]) check(got[i], {f && i == 4, exp[i]});
        end
        stop_test();
    end
endmodule : switch_mii_rmii_port_straps_tb_top
`default_nettype wire

/* File: logic/byte_stream_if.sv */
// Valid/ready stream carrier between the port logic and its FIFO
`timescale 1ns/1ps
`default_nettype none

interface byte_stream_if #(parameter int WIDTH = 9);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

`default_nettype wire

/* File: logic/mii_port_pkg.sv */
// Types shared by the MII/RMII port logic
`default_nettype none
package mii_port_pkg;

    typedef enum logic [0:0] {
        EG_IDLE = 1'b0,
        EG_SEND = 1'b1
    } egress_state_t;

    typedef logic [7:0] byte_t;

endpackage : mii_port_pkg

`default_nettype wire

/* File: logic/mii_port_regs.svh */
// Timing counts and strap bit positions for the MII/RMII port logic
`ifndef MII_PORT_REGS_SVH
`define MII_PORT_REGS_SVH

`define MP_CLK_MHZ          100
`define MP_MII100_CLK_MHZ   25
`define MP_MII10_CLK_MHZ_X10 25
`define MP_MII_HALF_100     (`MP_CLK_MHZ / (2 * `MP_MII100_CLK_MHZ))
`define MP_MII_HALF_10      ((`MP_CLK_MHZ * 10) / (2 * `MP_MII10_CLK_MHZ_X10))
`define MP_RMII_10M_REPEAT  10
`define MP_FIFO_DEPTH       8
`define MP_FIFO_WIDTH       9

`define MP_STRAP_BIT0       0
`define MP_STRAP_BIT1       1
`define MP_STRAP_BIT2       2
`define MP_STRAP_BIT3       3

`endif

/* File: logic/mii_port_straps.sv */
// Two switch MAC ports facing MII/RMII: straps, clocks and port-4 data path
// How it works
// - port-3 rx bit 2 high enables back pressure
// - port-3 rx bit 1 high keeps collided packets
// - port-3 rx bit 0 high selects aggressive back-off
// - port-4 rx bit 3 high enables flow control
// - port-4 rx bit 2 high selects half duplex
// - port-4 rx bit 1 high selects 10Mbps
// - port-4 tx clock output only in PHY mode
// - port-4 rx clock input/output/50MHz reference by mode
// - valid pin is data valid or CRS_DV
// - MII uses four bits, RMII two
// - port-3 carrier sense and collision only in MII
// - port-3 rx bit 3 low enables flow control
`timescale 1ns/1ps
`default_nettype none
`include "mii_port_regs.svh"

module mii_port_straps
    import mii_port_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       p3_mii_mode,
    input  wire logic       p4_mii_mode,
    input  wire logic       p4_phy_mode,
    input  wire logic       clock_mode_select_strap,
    input  wire logic       rmii_ref_out_enable,
    input  wire logic [3:0] p3_rx_pins_in,
    output logic      [3:0] p3_rx_pins_out,
    output logic      [3:0] p3_rx_pins_oe_n,
    output logic            p3_rx_valid,
    output logic            p3_carrier_sense,
    output logic            p3_collision,
    input  wire logic [3:0] p3_sw_rx_data,
    input  wire logic       p3_sw_rx_valid,
    input  wire logic       p3_sw_carrier,
    input  wire logic       p3_sw_collision,
    output logic            p3_backpressure_en,
    output logic            p3_keep_collided,
    output logic            p3_aggressive_backoff,
    output logic            p3_flowctl_en,
    output logic            p4_fd_flowctl_en,
    output logic            p4_half_duplex,
    output logic            p4_speed_10,
    input  wire logic       p4_tx_enable,
    input  wire logic [3:0] p4_tx_data,
    input  wire logic       p4_tx_clock_in,
    output logic            p4_tx_clock_out,
    output logic            p4_tx_clock_oe_n,
    input  wire logic       p4_rx_clock_in,
    output logic            p4_rx_clock_out,
    output logic            p4_rx_clock_oe_n,
    input  wire logic [3:0] p4_rx_pins_in,
    output logic      [3:0] p4_rx_pins_out,
    output logic      [3:0] p4_rx_pins_oe_n,
    output logic            p4_crs_valid,
    output logic      [7:0] ing_data,
    output logic            ing_last,
    output logic            ing_valid,
    input  wire logic       ing_ready,
    output logic            ing_overflow,
    input  wire logic [7:0] eg_data,
    input  wire logic       eg_last,
    input  wire logic       eg_valid,
    output logic            eg_ready
);
    // Strap capture
    logic       strap_done;
    logic [3:0] p3_strap;
    logic [3:1] p4_strap;
    logic       next_strap_done;
    logic [3:0] next_p3_strap;
    logic [3:1] next_p4_strap;

    always_comb begin
        next_strap_done = 1'b1;
        next_p3_strap   = p3_strap;
        next_p4_strap   = p4_strap;
        if (!strap_done) begin
            next_p3_strap = p3_rx_pins_in;
            next_p4_strap = p4_rx_pins_in[3:1];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            strap_done <= 1'b0;
            p3_strap   <= 4'h0;
            p4_strap   <= 3'h0;
        end else begin
            strap_done <= next_strap_done;
            p3_strap   <= next_p3_strap;
            p4_strap   <= next_p4_strap;
        end
    end

    // Clock generation and link edges
    logic       ref_q;
    logic       phy_clk;
    logic [4:0] phy_cnt;
    logic [3:0] rep_cnt;
    logic       tx_clk_prev;
    logic       rx_clk_prev;
    logic       next_ref_q;
    logic       next_phy_clk;
    logic [4:0] next_phy_cnt;
    logic [3:0] next_rep_cnt;
    logic       phy_rise;
    logic       ref_edge;
    logic       in_edge;
    logic       out_edge;
    logic       in_slot;
    logic       out_slot;
    logic       clk_mode;

    always_comb begin
        clk_mode     = clock_mode_select_strap;
        next_ref_q   = ~ref_q;
        phy_rise     = (phy_cnt == 5'h00) && !phy_clk;
        next_phy_clk = phy_clk;
        next_phy_cnt = phy_cnt - 5'h01;
        if (phy_cnt == 5'h00) begin
            next_phy_clk = ~phy_clk;
            next_phy_cnt = p4_strap[`MP_STRAP_BIT1] ? 5'(`MP_MII_HALF_10 - 1)
                                                     : 5'(`MP_MII_HALF_100 - 1);
        end
        ref_edge = clk_mode ? !ref_q : (p4_tx_clock_in && !tx_clk_prev);
        if (!p4_mii_mode) begin
            in_edge  = ref_edge;
            out_edge = ref_edge;
        end else if (p4_phy_mode) begin
            in_edge  = phy_rise;
            out_edge = phy_rise;
        end else begin
            in_edge  = p4_tx_clock_in && !tx_clk_prev;
            out_edge = p4_rx_clock_in && !rx_clk_prev;
        end
        next_rep_cnt = rep_cnt;
        if (ref_edge) begin
            next_rep_cnt = (rep_cnt == 4'(`MP_RMII_10M_REPEAT - 1)) ? 4'h0 : rep_cnt + 4'h1;
        end
        in_slot  = in_edge && (p4_mii_mode || !p4_strap[`MP_STRAP_BIT1] ||
                               rep_cnt == 4'h0);
        out_slot = out_edge && (p4_mii_mode || !p4_strap[`MP_STRAP_BIT1] ||
                                rep_cnt == 4'h0);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ref_q       <= 1'b0;
            phy_clk     <= 1'b0;
            phy_cnt     <= 5'h00;
            rep_cnt     <= 4'h0;
            tx_clk_prev <= 1'b0;
            rx_clk_prev <= 1'b0;
        end else begin
            ref_q       <= next_ref_q;
            phy_clk     <= next_phy_clk;
            phy_cnt     <= next_phy_cnt;
            rep_cnt     <= next_rep_cnt;
            tx_clk_prev <= p4_tx_clock_in;
            rx_clk_prev <= p4_rx_clock_in;
        end
    end

    // Ingress: assemble nibbles or dibits into bytes
    logic [7:0] in_sh;
    logic [1:0] in_cnt;
    logic [7:0] pend;
    logic       pend_v;
    logic       push;
    logic [8:0] push_word;
    logic [7:0] next_in_sh;
    logic [1:0] next_in_cnt;
    logic [7:0] next_pend;
    logic       next_pend_v;
    logic       next_push;
    logic [8:0] next_push_word;
    logic       byte_done;

    byte_stream_if #(.WIDTH(`MP_FIFO_WIDTH)) fifo_wr ();
    byte_stream_if #(.WIDTH(`MP_FIFO_WIDTH)) fifo_rd ();

    always_comb begin
        next_in_sh     = in_sh;
        next_in_cnt    = in_cnt;
        next_pend      = pend;
        next_pend_v    = pend_v;
        next_push      = 1'b0;
        next_push_word = push_word;
        byte_done      = 1'b0;
        if (in_slot && strap_done) begin
            if (p4_tx_enable) begin
                if (p4_mii_mode) begin
                    next_in_sh = {p4_tx_data, in_sh[7:4]};
                    byte_done  = (in_cnt == 2'd1);
                end else begin
                    next_in_sh = {p4_tx_data[1:0], in_sh[7:2]};
                    byte_done  = (in_cnt == 2'd3);
                end
                next_in_cnt = byte_done ? 2'd0 : in_cnt + 2'd1;
                if (byte_done) begin
                    next_pend   = next_in_sh;
                    next_pend_v = 1'b1;
                    next_push   = pend_v;
                    next_push_word = {1'b0, pend};
                end
            end else begin
                next_in_cnt = 2'd0;
                next_pend_v = 1'b0;
                next_push   = pend_v;
                next_push_word = {1'b1, pend};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            in_sh     <= 8'h00;
            in_cnt    <= 2'd0;
            pend      <= 8'h00;
            pend_v    <= 1'b0;
            push      <= 1'b0;
            push_word <= 9'h000;
        end else begin
            in_sh     <= next_in_sh;
            in_cnt    <= next_in_cnt;
            pend      <= next_pend;
            pend_v    <= next_pend_v;
            push      <= next_push;
            push_word <= next_push_word;
        end
    end

    assign fifo_wr.valid = push;
    assign fifo_wr.data  = push_word;

    stream_fifo #(.WIDTH(`MP_FIFO_WIDTH), .DEPTH(`MP_FIFO_DEPTH)) u_ing_fifo (
        .clk (clk),
        .rst (rst),
        .wr  (fifo_wr.snk),
        .rd  (fifo_rd.src)
    );

    // Output stage re-registers the FIFO head so outputs come from flops
    logic next_ing_valid;
    assign fifo_rd.ready = !ing_valid || ing_ready;

    always_comb begin
        next_ing_valid = ing_valid && !ing_ready;
        if (fifo_rd.ready && fifo_rd.valid) begin
            next_ing_valid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ing_valid    <= 1'b0;
            ing_data     <= 8'h00;
            ing_last     <= 1'b0;
            ing_overflow <= 1'b0;
        end else begin
            ing_valid    <= next_ing_valid;
            ing_overflow <= push && !fifo_wr.ready;
            if (fifo_rd.ready && fifo_rd.valid) begin
                ing_data <= fifo_rd.data[7:0];
                ing_last <= fifo_rd.data[8];
            end
        end
    end

    // Egress: serialise bytes onto the receive pins
    egress_state_t eg_state;
    egress_state_t next_eg_state;
    logic [7:0]    hold;
    logic          hold_last;
    logic          hold_v;
    logic [7:0]    eg_sh;
    logic          eg_cur_last;
    logic [1:0]    eg_rem;
    logic [3:0]    eg_unit;
    logic          eg_drive;
    logic [7:0]    next_hold;
    logic          next_hold_last;
    logic          next_hold_v;
    logic [7:0]    next_eg_sh;
    logic          next_eg_cur_last;
    logic [1:0]    next_eg_rem;
    logic [3:0]    next_eg_unit;
    logic          next_eg_drive;
    logic          load_ok;

    always_comb begin
        next_hold        = hold;
        next_hold_last   = hold_last;
        next_hold_v      = hold_v;
        next_eg_state    = eg_state;
        next_eg_sh       = eg_sh;
        next_eg_cur_last = eg_cur_last;
        next_eg_rem      = eg_rem;
        next_eg_unit     = eg_unit;
        next_eg_drive    = eg_drive;
        load_ok = hold_v && !(p4_strap[`MP_STRAP_BIT2] && p4_tx_enable);
        if (out_slot && strap_done) begin
            case (eg_state)
                EG_IDLE: begin
                    next_eg_drive = 1'b0;
                end
                EG_SEND: begin
                    next_eg_sh   = p4_mii_mode ? {4'h0, eg_sh[7:4]} : {2'b00, eg_sh[7:2]};
                    next_eg_rem  = eg_rem - 2'd1;
                    next_eg_unit = p4_mii_mode ? next_eg_sh[3:0]
                                               : {2'b00, next_eg_sh[1:0]};
                    if (eg_rem == 2'd0) begin
                        next_eg_drive = 1'b0;
                        next_eg_state = EG_IDLE;
                    end
                end
                default: begin
                    next_eg_state = EG_IDLE;
                end
            endcase
            if ((eg_state == EG_IDLE || (eg_rem == 2'd0 && !eg_cur_last)) && load_ok) begin
                next_eg_sh       = hold;
                next_eg_cur_last = hold_last;
                next_eg_rem      = p4_mii_mode ? 2'd1 : 2'd3;
                next_eg_unit     = p4_mii_mode ? hold[3:0] : {2'b00, hold[1:0]};
                next_eg_drive    = 1'b1;
                next_eg_state    = EG_SEND;
                next_hold_v      = 1'b0;
            end
        end
        if (eg_valid && eg_ready) begin
            next_hold      = eg_data;
            next_hold_last = eg_last;
            next_hold_v    = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            eg_state    <= EG_IDLE;
            hold        <= 8'h00;
            hold_last   <= 1'b0;
            hold_v      <= 1'b0;
            eg_ready    <= 1'b0;
            eg_sh       <= 8'h00;
            eg_cur_last <= 1'b0;
            eg_rem      <= 2'd0;
            eg_unit     <= 4'h0;
            eg_drive    <= 1'b0;
        end else begin
            eg_state    <= next_eg_state;
            hold        <= next_hold;
            hold_last   <= next_hold_last;
            hold_v      <= next_hold_v;
            eg_ready    <= !next_hold_v;
            eg_sh       <= next_eg_sh;
            eg_cur_last <= next_eg_cur_last;
            eg_rem      <= next_eg_rem;
            eg_unit     <= next_eg_unit;
            eg_drive    <= next_eg_drive;
        end
    end

    // Pin drivers and configuration outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            p3_rx_pins_out        <= 4'h0;
            p3_rx_pins_oe_n       <= 4'hf;
            p4_rx_pins_out        <= 4'h0;
            p4_rx_pins_oe_n       <= 4'hf;
            p3_rx_valid           <= 1'b0;
            p3_carrier_sense      <= 1'b0;
            p3_collision          <= 1'b0;
            p4_crs_valid          <= 1'b0;
            p4_tx_clock_out       <= 1'b0;
            p4_tx_clock_oe_n      <= 1'b1;
            p4_rx_clock_out       <= 1'b0;
            p4_rx_clock_oe_n      <= 1'b1;
            p3_backpressure_en    <= 1'b0;
            p3_keep_collided      <= 1'b0;
            p3_aggressive_backoff <= 1'b0;
            p3_flowctl_en         <= 1'b1;
            p4_fd_flowctl_en      <= 1'b0;
            p4_half_duplex        <= 1'b0;
            p4_speed_10           <= 1'b0;
        end else begin
            p3_rx_pins_oe_n       <= next_strap_done ? 4'h0 : 4'hf;
            p4_rx_pins_oe_n       <= next_strap_done ? 4'h0 : 4'hf;
            p3_rx_pins_out        <= p3_mii_mode ? p3_sw_rx_data
                                                 : {2'b00, p3_sw_rx_data[1:0]};
            p3_rx_valid           <= p3_sw_rx_valid;
            p3_carrier_sense      <= p3_mii_mode && p3_sw_carrier;
            p3_collision          <= p3_mii_mode && p3_sw_collision;
            p4_rx_pins_out        <= next_eg_unit;
            p4_crs_valid          <= next_eg_drive;
            p4_tx_clock_out       <= next_phy_clk;
            p4_tx_clock_oe_n      <= !(p4_mii_mode && p4_phy_mode);
            p4_rx_clock_out       <= p4_mii_mode ? next_phy_clk : next_ref_q;
            p4_rx_clock_oe_n      <= !((p4_mii_mode && p4_phy_mode) ||
                                       (!p4_mii_mode && clk_mode &&
                                        rmii_ref_out_enable));
            p3_backpressure_en    <= p3_strap[`MP_STRAP_BIT2];
            p3_keep_collided      <= p3_strap[`MP_STRAP_BIT1];
            p3_aggressive_backoff <= p3_strap[`MP_STRAP_BIT0];
            p3_flowctl_en         <= !p3_strap[`MP_STRAP_BIT3];
            p4_fd_flowctl_en      <= p4_strap[`MP_STRAP_BIT3];
            p4_half_duplex        <= p4_strap[`MP_STRAP_BIT2];
            p4_speed_10           <= p4_strap[`MP_STRAP_BIT1];
        end
    end

endmodule : mii_port_straps

`default_nettype wire

/* File: logic/stream_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module stream_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic  clk,
    input  wire logic  rst,
    byte_stream_if.snk wr,
    byte_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             do_wr;
    logic             do_rd;

    assign wr.ready = (count != (AW+1)'(DEPTH));
    assign rd.valid = (count != '0);
    assign rd.data  = mem[rd_ptr];

    always_comb begin
        do_wr       = wr.valid && wr.ready;
        do_rd       = rd.valid && rd.ready;
        next_wr_ptr = do_wr ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = do_rd ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count  = count;
        if (do_wr && !do_rd) begin
            next_count = count + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr.data;
        end
    end

endmodule : stream_fifo

`default_nettype wire
